// [design/ssrld_pkg.sv]
// Constants, types and carriers of the serial command and bus diagnostic
// block. Assumes a 100 MHz core clock and 4-bit register fields.
package ssrld_pkg;

  // Core clock rate
  localparam int unsigned CLK_HZ        = 100_000_000;
  // Stuck-dominant timeout on the transmit input
  localparam int unsigned STUCK_TIME_MS = 1000;
  localparam int unsigned STUCK_CYCLES  = STUCK_TIME_MS * (CLK_HZ / 1000);
  // Bus wake filter time, plain default
  localparam int unsigned WAKE_TIME_US  = 100;
  localparam int unsigned WAKE_CYCLES   = WAKE_TIME_US * (CLK_HZ / 1_000_000);

  // Frame length and sample counter saturation
  localparam logic [3:0] FRAME_BITS = 4'h8;
  localparam logic [3:0] ADDR_DONE  = 4'h3;
  localparam logic [3:0] CNT_SAT    = 4'hF;

  // Control register addresses
  localparam logic [3:0] ADDR_MODE   = 4'h0;
  localparam logic [3:0] ADDR_WAKE   = 4'h2;
  localparam logic [3:0] ADDR_BUS    = 4'h4;
  localparam logic [3:0] ADDR_HS     = 4'h6;
  localparam logic [3:0] ADDR_LS     = 4'h8;
  localparam logic [3:0] ADDR_TIMING = 4'hA;
  localparam logic [3:0] ADDR_AMUX   = 4'hC;
  localparam logic [3:0] ADDR_CONFIG = 4'hD;
  localparam logic [3:0] ADDR_MASK   = 4'hE;

  // Status groups, selected by address bits 3:1
  localparam logic [2:0] GRP_VOLT = 3'h0;
  localparam logic [2:0] GRP_WAKE = 3'h1;
  localparam logic [2:0] GRP_BUS  = 3'h2;
  localparam logic [2:0] GRP_HS   = 3'h3;
  localparam logic [2:0] GRP_LS   = 3'h4;
  localparam logic [2:0] GRP_WD   = 3'h5;
  localparam logic [2:0] GRP_ISR  = 3'h7;

  // Field positions
  localparam int BIT_OVS_EN  = 3;
  localparam int BIT_PU_EN   = 2;
  localparam int BIT_DOM_SEL = 3;
  localparam int BIT_RX_ONLY = 2;
  localparam int BIT_LAYOUT  = 3;
  localparam int BIT_HS      = 3;
  localparam int BIT_LS      = 2;
  localparam int BIT_BUS     = 1;
  localparam int BIT_VM      = 0;

  // Mode select codes and reserved slew code
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_STOP   = 2'h1;
  localparam logic [1:0] MODE_SLEEP  = 2'h2;
  localparam logic [1:0] MODE_WDCLR  = 2'h3;
  localparam logic [1:0] SLEW_RSVD   = 2'h3;

  // Reset values
  localparam logic [3:0] WAKE_EN_RST = 4'hF;
  localparam logic [3:0] NIB_ZERO    = 4'h0;
  localparam logic [2:0] TRI_ZERO    = 3'h0;

  // Synchronised pin positions and idle levels
  localparam int         PIN_CS   = 0;
  localparam int         PIN_SCLK = 1;
  localparam int         PIN_MOSI = 2;
  localparam int         PIN_EXT  = 3;
  localparam int         PIN_TXD  = 4;
  localparam int         PIN_RXD  = 5;
  localparam int         PIN_BUS  = 6;
  localparam int         NPIN     = 7;
  localparam logic [6:0] PIN_IDLE = 7'h79;

  // Operating mode
  typedef enum logic [1:0] {SSRLD_NORMAL, SSRLD_STOP, SSRLD_SLEEP}
    ssrld_mode_e;

  // Conditions from the analog side, same clock
  typedef struct packed {
    logic       overcurrent;   // Bus driver over current
    logic       overtemp;      // Bus driver over temperature
    logic       rx_short;      // Receive pin shorted
    logic [2:0] volt;          // Over volt, under volt, regulator hot
    logic [3:0] wake;          // Wake input levels
    logic [3:0] hs;            // High-side status
    logic [3:0] ls;            // Low-side status
    logic [3:0] wd;            // Watchdog status
  } ssrld_sense_s;

  // Control fields driven out
  typedef struct packed {
    logic       ovs_en;        // Over voltage shutdown enable
    logic       pullup_en;     // Bus pull-up enable
    logic [3:0] wake_en;       // Wake input enables
    logic       dom_sel;       // Dominant level select
    logic [1:0] slew;          // Slew select
    logic [3:0] hs;            // High-side control
    logic [3:0] ls;            // Low-side control
    logic [2:0] wd_period;     // Watchdog period select
    logic [2:0] cyc_period;    // Cyclic sense period select
    logic [3:0] amux;          // Analog select
    logic [3:0] config_bits;   // Configuration
  } ssrld_ctrl_s;

endpackage : ssrld_pkg

// [design/ssrld_core.sv]
// Serial command slave, register map and bus transceiver diagnostics.
// Assumes pins arrive asynchronous; sense inputs are on clk_in.
// Operation
// - Overcurrent: flag, receive-only bit stops driver, maskable interrupt
// - Receive short: flag, stop driver, interrupt
// - Short recovery: receive toggle and transmit high
// - Status read clears short flag once gone
// - Transmit low one second: stop, flag, interrupt
// - Transmit high lifts stuck block; read then clears flag
// - Receive-only bit stops driver in normal
// - Any bus error sets receive-only bit
// - Receive-only in low power: no wake; mirror in stop only
// - Stop: driver off, filtered wake interrupts
// - Sleep: driver off, filtered wake resets
// - Reply: summary nibble then addressed status
// - Select fall: start, drive output, snapshot
// - Shift on rising clock, sample falling
// - Only eight sample edges make a frame
// - Select rise commits; output released
// - Power-on, reset mode, reset pin restore bits
// - Even addresses and 0xD write; pair reads same status
// - Timing register has two layouts by bit 3
// - Mask holds four enables; source reads paired
// - Mode bits: normal, stop, sleep, watchdog clear
// - Mode or voltage access clears battery fail
// - Slew codes decoded; reserved code ignored
module ssrld_core #(
  parameter int unsigned STUCK_LIMIT = ssrld_pkg::STUCK_CYCLES, // Stuck time
  parameter int unsigned WAKE_LIMIT  = ssrld_pkg::WAKE_CYCLES   // Wake filter
) (
  input  wire logic                clk_in,         // Core clock
  input  wire logic                reset_n_in,     // Power-on reset
  input  wire logic                enable_in,      // Clock enable
  input  wire logic                reset_mode_in,  // Device in reset mode
  input  wire logic                ext_reset_n_in, // Reset pin
  input  wire logic                cs_n_in,        // Chip select pin
  input  wire logic                sclk_in,        // Serial clock pin
  input  wire logic                mosi_in,        // Serial data in pin
  input  wire logic                txd_in,         // Transmit data pin
  input  wire logic                rxd_sense_in,   // Receive pin level
  input  wire logic                bus_level_in,   // Bus receiver level
  input  wire ssrld_pkg::ssrld_sense_s sense_in,   // Analog conditions
  output logic                     miso_out,       // Serial data out
  output logic                     miso_oe_out,    // Serial out enable
  output logic                     irq_n_out,      // Interrupt, low active
  output logic                     tx_enable_out,  // Bus driver enable
  output logic                     rxd_out,        // Receive data out
  output logic                     wake_reset_out, // Sleep wake pulse
  output logic                     wd_clear_out,   // Watchdog clear pulse
  output ssrld_pkg::ssrld_mode_e   mode_out,       // Operating mode
  output ssrld_pkg::ssrld_ctrl_s   ctrl_out        // Control fields
);
  import ssrld_pkg::*;

  localparam int TXW = $clog2(STUCK_LIMIT + 1);    // Stuck counter width
  localparam int WKW = $clog2(WAKE_LIMIT + 1);     // Wake counter width

  logic [NPIN-1:0] pin_s1;          // First sync stage
  logic [NPIN-1:0] pin_s2;          // Second sync stage
  logic [NPIN-1:0] pin_s3;          // Third sync stage
  logic [NPIN-1:0] pin_f;           // Agreed pin levels
  logic [NPIN-1:0] pin_d;           // Agreed levels, one cycle old
  logic            cs_fall;         // Frame start
  logic            cs_rise;         // Frame end
  logic            sclk_rise;       // Shift edge
  logic            sclk_fall;       // Sample edge
  logic            soft_rst;        // Reset mode or reset pin
  logic [3:0]      bit_cnt;         // Sample edges seen
  logic [7:0]      rx_sh;           // Received byte
  logic [7:0]      tx_sh;           // Reply byte
  logic [7:0][3:0] snap;            // Status snapshot
  logic [7:0][3:0] status_all;      // Live status groups
  logic [3:0]      summary;         // Summary nibble
  logic [2:0]      peek_grp;        // Group from first address bits
  logic            commit;          // Valid frame end
  logic [3:0]      addr;            // Frame address
  logic [3:0]      data;            // Frame control nibble
  logic [2:0]      grp;             // Frame status group
  logic [3:0]      mask;            // Interrupt enables
  logic [3:0]      interrupt_source;             // Interrupt sources
  logic [3:0]      next_isr_set;    // Interrupt events
  logic            rx_only;         // Receive-only bit
  logic            bat_fail;        // Battery fail flag
  logic [3:0]      bus_flags;       // Short, dominant, hot, overcurrent
  logic            rxs_block;       // Driver held off by short
  logic            txd_block;       // Driver held off by stuck input
  logic [TXW-1:0]  txd_cnt;         // Transmit low time
  logic            txd_timeout;     // Transmit stuck low
  logic [WKW-1:0]  wake_cnt;        // Dominant time in low power
  logic            wake_evt;        // Filtered wake seen
  logic            bus_err;         // Any bus error now
  logic            bus_err_d;       // Bus error, one cycle old

  // Three-stage pin synchroniser, change taken once stages 2 and 3 agree
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      pin_s1 <= PIN_IDLE;
      pin_s2 <= PIN_IDLE;
      pin_s3 <= PIN_IDLE;
      pin_f  <= PIN_IDLE;
      pin_d  <= PIN_IDLE;
    end
    else if (enable_in)
    begin
      pin_s1 <= {bus_level_in, rxd_sense_in, txd_in, ext_reset_n_in,
                 mosi_in, sclk_in, cs_n_in};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f  <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 ^ pin_s3));
      pin_d  <= pin_f;
    end
  end

  // Edge detection on agreed levels
  assign cs_fall   = pin_d[PIN_CS] & ~pin_f[PIN_CS];
  assign cs_rise   = ~pin_d[PIN_CS] & pin_f[PIN_CS];
  assign sclk_rise = ~pin_d[PIN_SCLK] & pin_f[PIN_SCLK];
  assign sclk_fall = pin_d[PIN_SCLK] & ~pin_f[PIN_SCLK];
  assign soft_rst  = reset_mode_in | ~pin_f[PIN_EXT];

  // Status groups and summary
  assign status_all[GRP_VOLT] = {sense_in.volt, bat_fail};
  assign status_all[GRP_WAKE] = sense_in.wake & ctrl_out.wake_en;
  assign status_all[GRP_BUS]  = bus_flags;
  assign status_all[GRP_HS]   = sense_in.hs;
  assign status_all[GRP_LS]   = sense_in.ls;
  assign status_all[GRP_WD]   = sense_in.wd;
  assign status_all[6]        = NIB_ZERO;
  assign status_all[GRP_ISR]  = interrupt_source;
  assign summary = {|status_all[GRP_VOLT], |bus_flags,
                    |sense_in.hs, |sense_in.ls};

  // Frame fields
  assign peek_grp = rx_sh[2:0];
  assign addr     = rx_sh[7:4];
  assign data     = rx_sh[3:0];
  assign grp      = addr[3:1];
  assign commit   = cs_rise && (bit_cnt == FRAME_BITS);

  // Serial shift engine
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      bit_cnt     <= NIB_ZERO;
      rx_sh       <= {NIB_ZERO, NIB_ZERO};
      tx_sh       <= {NIB_ZERO, NIB_ZERO};
      snap        <= '0;
      miso_out    <= 1'b0;
      miso_oe_out <= 1'b0;
    end
    else if (enable_in)
    begin
      if (cs_fall)
      begin
        // Start frame, drive output, freeze status
        bit_cnt     <= NIB_ZERO;
        snap        <= status_all;
        tx_sh       <= {summary, NIB_ZERO};
        miso_out    <= summary[3];
        miso_oe_out <= 1'b1;
      end
      else if (pin_f[PIN_CS])
      begin
        // Deselected, output released
        miso_oe_out <= 1'b0;
      end
      else
      begin
        if (sclk_rise)
        begin
          // Move next reply bit onto the line
          miso_out <= tx_sh[7];
          tx_sh    <= {tx_sh[6:0], 1'b0};
        end
        else if (sclk_fall)
        begin
          // Sample incoming bit
          rx_sh <= {rx_sh[6:0], pin_f[PIN_MOSI]};
          if (bit_cnt != CNT_SAT)
          begin
            bit_cnt <= bit_cnt + 4'h1;
          end
          if (bit_cnt == ADDR_DONE)
          begin
            // Address known: load the paired status
            tx_sh[7:4] <= snap[peek_grp];
          end
        end
      end
    end
  end

  // Control registers
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      ctrl_out     <= '0;
      ctrl_out.ovs_en    <= 1'b1;
      ctrl_out.pullup_en <= 1'b1;
      ctrl_out.wake_en   <= WAKE_EN_RST;
      mode_out     <= SSRLD_NORMAL;
      rx_only      <= 1'b0;
      mask         <= NIB_ZERO;
      wd_clear_out <= 1'b0;
    end
    else if (enable_in)
    begin
      wd_clear_out <= 1'b0;
      if (soft_rst)
      begin
        // Bits restored by reset mode or reset pin
        ctrl_out.wake_en <= WAKE_EN_RST;
        ctrl_out.dom_sel <= 1'b0;
        rx_only          <= 1'b0;
        mode_out         <= SSRLD_NORMAL;
      end
      else if (commit)
      begin
        case (addr)
          ADDR_MODE:
          begin
            ctrl_out.ovs_en    <= data[BIT_OVS_EN];
            ctrl_out.pullup_en <= data[BIT_PU_EN];
            case (data[1:0])
              MODE_STOP:   mode_out <= SSRLD_STOP;
              MODE_SLEEP:  mode_out <= SSRLD_SLEEP;
              MODE_WDCLR:
              begin
                mode_out     <= SSRLD_NORMAL;
                wd_clear_out <= 1'b1;
              end
              default:     mode_out <= SSRLD_NORMAL;
            endcase
          end
          ADDR_WAKE:   ctrl_out.wake_en <= data;
          ADDR_BUS:
          begin
            ctrl_out.dom_sel <= data[BIT_DOM_SEL];
            rx_only          <= data[BIT_RX_ONLY] | bus_err;
            if (data[1:0] != SLEW_RSVD)
            begin
              ctrl_out.slew <= data[1:0];
            end
          end
          ADDR_HS:     ctrl_out.hs <= data;
          ADDR_LS:     ctrl_out.ls <= data;
          ADDR_TIMING:
          begin
            // Layout chosen by the top bit
            if (data[BIT_LAYOUT])
            begin
              ctrl_out.cyc_period <= data[2:0];
            end
            else
            begin
              ctrl_out.wd_period <= data[2:0];
            end
          end
          ADDR_AMUX:   ctrl_out.amux <= data;
          ADDR_CONFIG: ctrl_out.config_bits <= data;
          ADDR_MASK:   mask <= data;
          default:     mask <= mask;   // Status-only addresses
        endcase
      end
      // Events win over writes
      if (!soft_rst)
      begin
        if (bus_err && !bus_err_d)
        begin
          rx_only <= 1'b1;
        end
        if (wake_evt)
        begin
          mode_out <= SSRLD_NORMAL;
        end
      end
    end
  end

  // Transmit stuck-low timer
  assign txd_timeout = (txd_cnt == TXW'(STUCK_LIMIT));
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      txd_cnt <= '0;
    end
    else if (enable_in)
    begin
      if (pin_f[PIN_TXD])
      begin
        txd_cnt <= '0;
      end
      else if (!txd_timeout)
      begin
        txd_cnt <= txd_cnt + TXW'(1);
      end
    end
  end

  // Bus diagnostic flags and driver blocks
  assign bus_err = sense_in.overcurrent | sense_in.overtemp |
                   sense_in.rx_short | txd_timeout;
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      bus_flags <= NIB_ZERO;
      rxs_block <= 1'b0;
      txd_block <= 1'b0;
      bus_err_d <= 1'b0;
    end
    else if (enable_in)
    begin
      bus_err_d <= bus_err;
      // Overcurrent: flag only, no block; driver stops via receive-only bit
      if (sense_in.overcurrent)
      begin
        bus_flags[0] <= 1'b1;
      end
      else if (commit && grp == GRP_BUS)
      begin
        bus_flags[0] <= 1'b0;
      end
      // Over temperature flag
      if (sense_in.overtemp)
      begin
        bus_flags[1] <= 1'b1;
      end
      else if (commit && grp == GRP_BUS)
      begin
        bus_flags[1] <= 1'b0;
      end
      // Stuck dominant flag, read clears only with transmit high
      if (txd_timeout)
      begin
        bus_flags[2] <= 1'b1;
      end
      else if (commit && grp == GRP_BUS && pin_f[PIN_TXD])
      begin
        bus_flags[2] <= 1'b0;
      end
      // Receive short flag, read clears only once gone
      if (sense_in.rx_short)
      begin
        bus_flags[3] <= 1'b1;
      end
      else if (commit && grp == GRP_BUS)
      begin
        bus_flags[3] <= 1'b0;
      end
      // Short block until receive toggles with transmit high
      if (sense_in.rx_short)
      begin
        rxs_block <= 1'b1;
      end
      else if ((pin_f[PIN_RXD] ^ pin_d[PIN_RXD]) && pin_f[PIN_TXD])
      begin
        rxs_block <= 1'b0;
      end
      // Stuck block until transmit returns high
      if (txd_timeout)
      begin
        txd_block <= 1'b1;
      end
      else if (pin_f[PIN_TXD])
      begin
        txd_block <= 1'b0;
      end
    end
  end

  // Battery fail flag, set by power-on only
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      bat_fail <= 1'b1;
    end
    else if (enable_in && commit && grp == GRP_VOLT)
    begin
      bat_fail <= 1'b0;
    end
  end

  // Bus wake filter in low power modes
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      wake_cnt <= '0;
      wake_evt <= 1'b0;
    end
    else if (enable_in)
    begin
      wake_evt <= 1'b0;
      if (mode_out == SSRLD_NORMAL || rx_only)
      begin
        wake_cnt <= '0;
      end
      else if (!pin_f[PIN_BUS])
      begin
        if (wake_cnt != WKW'(WAKE_LIMIT))
        begin
          wake_cnt <= wake_cnt + WKW'(1);
        end
      end
      else
      begin
        // Rising edge after long dominant
        wake_evt <= !pin_d[PIN_BUS] &&
                    (wake_cnt == WKW'(WAKE_LIMIT));
        wake_cnt <= '0;
      end
    end
  end

  // Interrupt sources, event wins over read clear
  always_comb
  begin
    next_isr_set          = NIB_ZERO;
    next_isr_set[BIT_HS]  = |sense_in.hs;
    next_isr_set[BIT_LS]  = |sense_in.ls;
    next_isr_set[BIT_BUS] = bus_err | wake_evt;
    next_isr_set[BIT_VM]  = |sense_in.volt;
  end

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      interrupt_source <= NIB_ZERO;
    end
    else if (enable_in)
    begin
      if (commit && grp == GRP_ISR)
      begin
        interrupt_source <= next_isr_set;
      end
      else
      begin
        interrupt_source <= interrupt_source | next_isr_set;
      end
    end
  end

  // Registered pin outputs
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      irq_n_out      <= 1'b1;
      tx_enable_out  <= 1'b0;
      rxd_out        <= 1'b1;
      wake_reset_out <= 1'b0;
    end
    else if (enable_in)
    begin
      irq_n_out <= ~|(interrupt_source & mask);
      // Driver on only in normal mode with no block
      tx_enable_out <= (mode_out == SSRLD_NORMAL) && !rx_only &&
                       !rxs_block && !txd_block &&
                       !sense_in.overtemp;
      // Receive data mirrors the bus in normal, or stop with receive-only
      if (mode_out == SSRLD_NORMAL ||
          (mode_out == SSRLD_STOP && rx_only))
      begin
        rxd_out <= pin_f[PIN_BUS];
      end
      else
      begin
        rxd_out <= 1'b1;
      end
      wake_reset_out <= wake_evt && (mode_out == SSRLD_SLEEP);
    end
  end

endmodule : ssrld_core

// [test/ssrld_spi_master.sv]
// Partner model: serial bus master sending one-byte frames.
// Assumes clk_in paces it; the serial clock idles low between frames.
module ssrld_spi_master (
  input  wire logic clk_in,   // Pacing clock
  input  wire logic miso_in,  // Reply from the slave
  output logic      cs_n_out, // Select, low active
  output logic      sclk_out, // Serial clock, 160 ns period
  output logic      mosi_out  // Command to the slave
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle levels from time zero
  initial
  begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    mosi_out = 1'b0;
  end

  // One frame of n sample edges, address nibble then control nibble
  task automatic xfer(input logic [7:0] tx, input int n,
                      output logic [7:0] rx);
    rx = 8'h00;
    @(negedge clk_in);
    cs_n_out = 1'b0;
    repeat (10) @(negedge clk_in);
    for (int i = 0; i < n; i++)
    begin
      sclk_out = 1'b1;
      mosi_out = tx[3'(7 - i)];
      repeat (8) @(negedge clk_in);
      rx = {rx[6:0], miso_in};
      sclk_out = 1'b0;
      repeat (8) @(negedge clk_in);
    end
    cs_n_out = 1'b1;
    mosi_out = ~mosi_out;
    repeat (12) @(negedge clk_in);
  endtask : xfer
endmodule : ssrld_spi_master

// [test/ssrld_core_asserts.sv]
// Checker: port-level properties of the serial command block.
// Assumes enable_in high; bound from the bench's top file.
module ssrld_core_asserts
  import ssrld_pkg::*;
#(
  parameter int unsigned STUCK_LIMIT = 200 // Stuck-low limit
) (
  input wire logic                   clk_in,
  input wire logic                   reset_n_in,
  input wire logic                   cs_n_in,
  input wire logic                   txd_in,
  input wire ssrld_pkg::ssrld_sense_s sense_in,
  input wire logic                   miso_oe_out,
  input wire logic                   irq_n_out,
  input wire logic                   tx_enable_out,
  input wire logic                   wake_reset_out,
  input wire logic                   wd_clear_out,
  input wire ssrld_pkg::ssrld_mode_e mode_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned low_cnt; // Cycles the transmit pin sat low
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  // Count an unbroken low on the transmit pin
  always_ff @(posedge clk_in)
    if (!reset_n_in || txd_in)
      low_cnt <= 0;
    else if (low_cnt < 1000)
      low_cnt <= low_cnt + 1;

  sequence s_open;
    $fell(cs_n_in) ##0 (!cs_n_in)[*8];
  endsequence
  sequence s_idle;
    cs_n_in[*8];
  endsequence

  a_oe_frame: assert property (s_open ##1 !cs_n_in |-> miso_oe_out)
    else $error("miso not driven in frame");
  a_oe_idle: assert property (s_idle |-> !miso_oe_out)
    else $error("miso driven while deselected");
  a_short_tx: assert property (sense_in.rx_short |-> ##2 !tx_enable_out)
    else $error("driver on during receive short");
  a_dom_tx: assert property (low_cnt > STUCK_LIMIT + 8 |->
    !tx_enable_out)
    else $error("driver on after stuck low");
  a_lowpwr_tx: assert property (
    (mode_out != SSRLD_NORMAL)[*2] |-> !tx_enable_out)
    else $error("driver on in low power");
  a_wake_one: assert property (wake_reset_out |=>
    !wake_reset_out ##[0:2] mode_out == SSRLD_NORMAL)
    else $error("wake pulse wrong");
  a_wdclr_one: assert property (wd_clear_out |=>
    !wd_clear_out && mode_out == SSRLD_NORMAL)
    else $error("watchdog clear pulse wrong");
  a_reset_idle: assert property (@(posedge clk_in) disable iff (1'b0)
    !reset_n_in |=> !miso_oe_out && irq_n_out && mode_out == SSRLD_NORMAL)
    else $error("outputs not idle in reset");
endmodule : ssrld_core_asserts

// [test/ssrld_core_tb_top.sv]
// Bench top: runs the serial command block through its pins.
// Assumes shortened limits; the partner model runs the frames.
module ssrld_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ssrld_pkg::*;
  localparam int unsigned STUCK_LIMIT = 200; // Short stuck limit
  logic         clk_in = 1'b0;         // Core clock
  logic         reset_n_in = 1'b0;     // Power-on reset
  logic         ext_reset_n_in = 1'b1; // Reset pin
  logic         reset_mode_in = 1'b0;  // Reset mode
  logic         txd_in = 1'b1;         // Transmit pin
  logic         rxd_sense_in = 1'b1;   // Receive pin level
  logic         bus_level_in = 1'b1;   // Bus level, recessive
  ssrld_sense_s sense_in = '0;         // Analog conditions
  logic         cs_n, sclk, mosi, miso, miso_oe, irq_n, tx_en, rxd;
  logic         wake_rst, wd_clr;      // Pulses
  ssrld_mode_e  mode;                  // Operating mode
  ssrld_ctrl_s  ctrl;                  // Control fields
  logic [7:0]   rx;                    // Last reply
  int           err_count = 0, comparisons = 0, wake_cnt = 0, wd_cnt = 0;

  always #5 clk_in = ~clk_in;
  // Tally the one-cycle pulses
  always @(posedge clk_in)
  begin
    wake_cnt += int'(wake_rst === 1'b1);
    wd_cnt += int'(wd_clr === 1'b1);
  end

  ssrld_core #(.STUCK_LIMIT(STUCK_LIMIT), .WAKE_LIMIT(50)) i_ssrld_core (
    .clk_in, .reset_n_in, .enable_in(1'b1), .reset_mode_in,
    .ext_reset_n_in, .cs_n_in(cs_n), .sclk_in(sclk), .mosi_in(mosi),
    .txd_in, .rxd_sense_in, .bus_level_in, .sense_in, .miso_out(miso),
    .miso_oe_out(miso_oe), .irq_n_out(irq_n), .tx_enable_out(tx_en),
    .rxd_out(rxd), .wake_reset_out(wake_rst), .wd_clear_out(wd_clr),
    .mode_out(mode), .ctrl_out(ctrl));
  ssrld_spi_master i_ssrld_spi_master (.clk_in, .miso_in(miso),
    .cs_n_out(cs_n), .sclk_out(sclk), .mosi_out(mosi));

  task automatic w(int n);
    repeat (n) @(negedge clk_in);
  endtask : w
  task automatic final_report();
    $display("err_count %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(logic [7:0] b);
    i_ssrld_spi_master.xfer(b, 8, rx);
  endtask : wr
  task automatic rd(logic [7:0] b, logic [7:0] e);
    wr(b);
    chk($sformatf("reply %h", b), e, rx);
  endtask : rd
  // Bounded wait for a pulse count to move
  task automatic wait_cnt(ref int c);
    for (int k = 0; k < 100 && c == 0; k++)
      w(1);
    chk("pulse", 1, 8'(c > 0));
    if (c == 0)
      final_report();
  endtask : wait_cnt
  task automatic bus_pulse();
    bus_level_in = 1'b0;
    w(70);
    bus_level_in = 1'b1;
    w(10);
  endtask : bus_pulse

  task automatic t_frames();
    chk("ctrl", 8'h3F, {ctrl.ovs_en, ctrl.pullup_en, ctrl.wake_en});
    i_ssrld_spi_master.xfer(8'h10, 7, rx);
    rd(8'h10, 8'h81);
    rd(8'h10, 8'h00);
  endtask : t_frames
  task automatic t_regs();
    wr(8'h4A);
    wr(8'h4B);
    wr(8'h50);
    chk("dom_sel", 1, ctrl.dom_sel);
    chk("slew", 2, ctrl.slew);
    wr(8'hAB);
    wr(8'hA5);
    chk("cyc", 3, ctrl.cyc_period);
    chk("wd", 5, ctrl.wd_period);
    wr(8'h23);
    ext_reset_n_in = 1'b0;
    w(8);
    ext_reset_n_in = 1'b1;
    w(8);
    chk("dom_rst", 0, ctrl.dom_sel);
    chk("slew_kept", 2, ctrl.slew);
    chk("wake_rst", 8'hF, ctrl.wake_en);
    wr(8'h23);
    reset_mode_in = 1'b1;
    w(2);
    reset_mode_in = 1'b0;
    chk("wake_mode", 8'hF, ctrl.wake_en);
  endtask : t_regs
  task automatic t_short();
    wr(8'hE2);
    sense_in.rx_short = 1'b1;
    w(4);
    chk("tx_short", 0, tx_en);
    chk("irq_short", 0, irq_n);
    rd(8'h50, 8'h48);
    sense_in.rx_short = 1'b0;
    rd(8'h50, 8'h48);
    rd(8'h50, 8'h00);
    rd(8'hF0, 8'h02);
    chk("irq_clr", 1, irq_n);
    sense_in.overcurrent = 1'b1;
    w(4);
    chk("irq_oc", 0, irq_n);
    sense_in.overcurrent = 1'b0;
    rd(8'h50, 8'h41);
    rd(8'hF0, 8'h02);
    chk("tx_receive_only_bit", 0, tx_en);
    rxd_sense_in = 1'b0;
    w(8);
    rxd_sense_in = 1'b1;
    w(8);
    wr(8'h40);
    chk("tx_back", 1, tx_en);
    wr(8'h44);
    chk("tx_receive_only_bit", 0, tx_en);
    wr(8'h40);
  endtask : t_short
  task automatic t_transmit_dominant_flag();
    txd_in = 1'b0;
    w(STUCK_LIMIT + 20);
    chk("tx_dom", 0, tx_en);
    chk("irq_dom", 0, irq_n);
    rd(8'h50, 8'h44);
    txd_in = 1'b1;
    w(8);
    rd(8'h50, 8'h44);
    rd(8'h50, 8'h00);
    rd(8'hF0, 8'h02);
    wr(8'h40);
    chk("tx_dom_back", 1, tx_en);
  endtask : t_transmit_dominant_flag
  task automatic t_modes();
    wr(8'h0D);
    chk("stop", SSRLD_STOP, mode);
    bus_pulse();
    chk("woke", SSRLD_NORMAL, mode);
    rd(8'hF0, 8'h02);
    wr(8'h0E);
    chk("sleep", SSRLD_SLEEP, mode);
    bus_pulse();
    wait_cnt(wake_cnt);
    wr(8'h0F);
    wait_cnt(wd_cnt);
    wr(8'h44);
    wr(8'h0D);
    bus_level_in = 1'b0;
    w(70);
    chk("mirror", 0, rxd);
    bus_level_in = 1'b1;
    w(10);
    chk("no_wake", SSRLD_STOP, mode);
    wr(8'h0C);
    chk("normal", SSRLD_NORMAL, mode);
  endtask : t_modes

  initial
  begin
    w(6);
    reset_n_in = 1'b1;
    w(5);
    t_frames();
    t_regs();
    t_short();
    t_transmit_dominant_flag();
    t_modes();
    final_report();
  end
endmodule : ssrld_core_tb_top

bind ssrld_core ssrld_core_asserts #(.STUCK_LIMIT(STUCK_LIMIT))
  i_ssrld_core_asserts (.clk_in, .reset_n_in, .cs_n_in, .txd_in,
  .sense_in, .miso_oe_out, .irq_n_out, .tx_enable_out, .wake_reset_out,
  .wd_clear_out, .mode_out);
